/* File: rtl/mbs_params.svh */
// Constants for the multiply, branch and skip execution block
`ifndef MBS_PARAMS_SVH
`define MBS_PARAMS_SVH

// ----------------------------------------------------------------
// Cycle counts per instruction class
// ----------------------------------------------------------------
`define MBS_CYC_MUL 3'h2
`define MBS_CYC_PTR_JMP 3'h2
`define MBS_CYC_REL_JMP 3'h2
`define MBS_CYC_ABS_JMP 3'h3
`define MBS_CYC_REL_CALL 3'h3
`define MBS_CYC_ABS_CALL 3'h4
`define MBS_CYC_CMP 3'h1
`define MBS_CYC_NO_SKIP 3'h1
`define MBS_CYC_SKIP_ONE 3'h2
`define MBS_CYC_SKIP_TWO 3'h3
`define MBS_CYC_BR_NOT 3'h1
`define MBS_CYC_BR_TAKEN 3'h2

// ----------------------------------------------------------------
// Program counter steps
// ----------------------------------------------------------------
`define MBS_PC_STEP 16'h0001
`define MBS_PC_SKIP_ONE 16'h0002
`define MBS_PC_SKIP_TWO 16'h0003

// ----------------------------------------------------------------
// Status flag bit positions
// ----------------------------------------------------------------
`define MBS_FLG_C 0
`define MBS_FLG_Z 1
`define MBS_FLG_N 2
`define MBS_FLG_V 3
`define MBS_FLG_S 4
`define MBS_FLG_H 5
`define MBS_FLG_T 6
`define MBS_FLG_I 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MBS_RST_PC 16'h0000
`define MBS_RST_PROD 16'h0000
`define MBS_RST_FLAGS 8'h00
`define MBS_RST_CNT 3'h0

`endif

/* File: rtl/mbs_pkg.sv */
// Types shared by the multiply, branch and skip execution block
package mbs_pkg;

  // ----------------------------------------------------------------
  // Decoded operations handed over by the decoder
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    multiply_unsigned_op,
    multiply_signed_op,
    multiply_signed_by_unsigned_op,
    fractional_multiply_unsigned_op,
    fractional_multiply_signed_op,
    fractional_multiply_mixed_op,
    relative_jump_op,
    pointer_jump_op,
    absolute_jump_op,
    relative_call_op,
    absolute_call_op,
    compare_skip_equal_op,
    compare_op,
    compare_carry_op,
    compare_immediate_op,
    skip_reg_bit_clear_op,
    skip_reg_bit_set_op,
    skip_io_bit_clear_op,
    skip_io_bit_set_op,
    branch_flag_set_op,
    branch_flag_clear_op,
    branch_same_higher_op,
    branch_lower_op,
    branch_signed_less_op,
    branch_irq_enabled_op,
    branch_irq_disabled_op,
    branch_half_carry_set_op,
    branch_half_carry_clear_op,
    branch_transfer_bit_set_op,
    branch_transfer_bit_clear_op,
    branch_overflow_set_op,
    branch_overflow_clear_op
  } mbs_op_type;

  // Sequencer states
  typedef enum logic {
    st_idle,
    st_run
  } mbs_state_type;

endpackage : mbs_pkg

/* File: rtl/mbs_exec.sv */
// Execution unit for multiply, jump, call, compare, skip and branch operations
//
// How it works
// - Integer multiplies take two cycles, product to pair one:zero, only Z and C change.
// - Fractional multiplies take two cycles, product shifted left one, Z and C change.
// - Pointer jump loads PC from the Z pointer in two cycles, flags untouched.
// - Relative call sets PC to PC plus offset plus one in three cycles.
// - Absolute call takes four cycles, absolute jump three, no flag changes.
// - Compare-skip-equal advances PC by 2 or 3 when equal, 1/2/3 cycles.
// - Compares form the difference unstored, update Z N V C H in one cycle.
// - Register bit skips test one bit and skip on clear or set.
// - I/O bit skips test one I/O bit and skip on set or clear.
// - Generic branch tests selected flag, target PC plus offset plus one, 1/2 cycles.
// - Same-or-higher branches on carry zero, lower branches on carry one.
// - Signed less-than branches when negative XOR overflow is one.
// - Interrupt branches test the global enable flag for one or zero.
// - Half-carry branches test the half-carry flag for one or zero.
// - Transfer-bit branches test the T flag for one or zero.
// - Overflow branches test the overflow flag for one or zero.
`timescale 1ns/1ps
`include "mbs_params.svh"

module mbs_exec (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  input wire mbs_pkg::mbs_op_type op,
  input wire logic [7:0] opd_a,
  input wire logic [7:0] source_operand,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] io_val,
  input wire logic [11:0] rel_off,
  input wire logic [15:0] abs_target,
  input wire logic [15:0] z_ptr,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] status_flags_register,
  input wire logic next_two_word,
  output logic busy_r,
  output logic done_r,
  output logic pc_load_r,
  output logic [15:0] pc_out_r,
  output logic prod_we_r,
  output logic [15:0] product_register_pair,
  output logic flags_we_r,
  output logic [7:0] flags_out_r
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Flag test shared by every flag-driven branch
  function automatic logic branch_cond(input mbs_pkg::mbs_op_type o, input logic [7:0] f,
                                       input logic [2:0] s);
    case (o)
      mbs_pkg::branch_flag_set_op: branch_cond = f[s];
      mbs_pkg::branch_flag_clear_op: branch_cond = !f[s];
      mbs_pkg::branch_same_higher_op: branch_cond = !f[`MBS_FLG_C];
      mbs_pkg::branch_lower_op: branch_cond = f[`MBS_FLG_C];
      mbs_pkg::branch_signed_less_op: branch_cond = f[`MBS_FLG_N] ^ f[`MBS_FLG_V];
      mbs_pkg::branch_irq_enabled_op: branch_cond = f[`MBS_FLG_I];
      mbs_pkg::branch_irq_disabled_op: branch_cond = !f[`MBS_FLG_I];
      mbs_pkg::branch_half_carry_set_op: branch_cond = f[`MBS_FLG_H];
      mbs_pkg::branch_half_carry_clear_op: branch_cond = !f[`MBS_FLG_H];
      mbs_pkg::branch_transfer_bit_set_op: branch_cond = f[`MBS_FLG_T];
      mbs_pkg::branch_transfer_bit_clear_op: branch_cond = !f[`MBS_FLG_T];
      mbs_pkg::branch_overflow_set_op: branch_cond = f[`MBS_FLG_V];
      mbs_pkg::branch_overflow_clear_op: branch_cond = !f[`MBS_FLG_V];
      default: branch_cond = 1'b0;
    endcase
  endfunction : branch_cond

  // Relative target, also used by the checks below
  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [11:0] k);
    rel_target = pc + {{4{k[11]}}, k} + `MBS_PC_STEP;
  endfunction : rel_target

  // ----------------------------------------------------------------
  // Datapath terms
  // ----------------------------------------------------------------
  logic sign_a;
  logic sign_b;
  logic frac;
  logic signed [17:0] prod_full;
  logic [15:0] prod_res;
  logic cmp_cin;
  logic [7:0] diff;
  logic skip_cond;
  logic [15:0] skip_pc;
  logic [2:0] skip_cyc;
  logic br_taken;

  // Operand signedness and fractional shift per multiply flavour
  always_comb begin
    sign_a = (op == mbs_pkg::multiply_signed_op) ||
             (op == mbs_pkg::multiply_signed_by_unsigned_op) ||
             (op == mbs_pkg::fractional_multiply_signed_op) ||
             (op == mbs_pkg::fractional_multiply_mixed_op);
    sign_b = (op == mbs_pkg::multiply_signed_op) ||
             (op == mbs_pkg::fractional_multiply_signed_op);
    frac = (op == mbs_pkg::fractional_multiply_unsigned_op) ||
           (op == mbs_pkg::fractional_multiply_signed_op) ||
           (op == mbs_pkg::fractional_multiply_mixed_op);
  end

  // One 9x9 signed multiplier covers all six flavours by extending operands
  assign prod_full = $signed({sign_a & opd_a[7], opd_a}) *
                     $signed({sign_b & source_operand[7], source_operand});
  assign prod_res = frac ? {prod_full[14:0], 1'b0} : prod_full[15:0];

  // Carry-in only for compare with carry
  assign cmp_cin = (op == mbs_pkg::compare_carry_op) & status_flags_register[`MBS_FLG_C];
  assign diff = opd_a - source_operand - {7'h00, cmp_cin};

  // Skip condition and the PC step over one- or two-word instructions
  always_comb begin
    case (op)
      mbs_pkg::compare_skip_equal_op: skip_cond = (opd_a == source_operand);
      mbs_pkg::skip_reg_bit_clear_op: skip_cond = !source_operand[bit_sel];
      mbs_pkg::skip_reg_bit_set_op: skip_cond = source_operand[bit_sel];
      mbs_pkg::skip_io_bit_clear_op: skip_cond = !io_val[bit_sel];
      mbs_pkg::skip_io_bit_set_op: skip_cond = io_val[bit_sel];
      default: skip_cond = 1'b0;
    endcase
    if (!skip_cond) begin
      skip_pc = pc_in + `MBS_PC_STEP;
      skip_cyc = `MBS_CYC_NO_SKIP;
    end else if (next_two_word) begin
      skip_pc = pc_in + `MBS_PC_SKIP_TWO;
      skip_cyc = `MBS_CYC_SKIP_TWO;
    end else begin
      skip_pc = pc_in + `MBS_PC_SKIP_ONE;
      skip_cyc = `MBS_CYC_SKIP_ONE;
    end
  end

  assign br_taken = branch_cond(op, status_flags_register, bit_sel);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  mbs_pkg::mbs_state_type state_r;
  mbs_pkg::mbs_state_type state_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic busy_nxt;
  logic done_nxt;
  logic pc_load_nxt;
  logic [15:0] pc_out_nxt;
  logic prod_we_nxt;
  logic [15:0] prod_nxt;
  logic flags_we_nxt;
  logic [7:0] flags_out_nxt;
  logic pend_prod_r;
  logic pend_prod_nxt;
  logic pend_flags_r;
  logic pend_flags_nxt;
  logic [2:0] cyc;
  logic take;

  assign take = start && (state_r == mbs_pkg::st_idle);

  // Results are latched at acceptance; strobes fire only when the count expires
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    pc_load_nxt = 1'b0;
    prod_we_nxt = 1'b0;
    flags_we_nxt = 1'b0;
    pc_out_nxt = pc_out_r;
    prod_nxt = product_register_pair;
    flags_out_nxt = flags_out_r;
    pend_prod_nxt = pend_prod_r;
    pend_flags_nxt = pend_flags_r;
    cyc = `MBS_CYC_CMP;
    case (state_r)
      mbs_pkg::st_idle: begin
        if (start) begin
          pend_prod_nxt = 1'b0;
          pend_flags_nxt = 1'b0;
          flags_out_nxt = status_flags_register;
          pc_out_nxt = pc_in + `MBS_PC_STEP;
          case (op)
            mbs_pkg::multiply_unsigned_op, mbs_pkg::multiply_signed_op,
            mbs_pkg::multiply_signed_by_unsigned_op, mbs_pkg::fractional_multiply_unsigned_op,
            mbs_pkg::fractional_multiply_signed_op, mbs_pkg::fractional_multiply_mixed_op: begin
              cyc = `MBS_CYC_MUL;
              prod_nxt = prod_res;
              pend_prod_nxt = 1'b1;
              pend_flags_nxt = 1'b1;
              flags_out_nxt[`MBS_FLG_C] = prod_full[15];
              flags_out_nxt[`MBS_FLG_Z] = (prod_res == 16'h0000);
            end
            mbs_pkg::relative_jump_op: begin
              cyc = `MBS_CYC_REL_JMP;
              pc_out_nxt = rel_target(pc_in, rel_off);
            end
            mbs_pkg::pointer_jump_op: begin
              cyc = `MBS_CYC_PTR_JMP;
              pc_out_nxt = z_ptr;
            end
            mbs_pkg::absolute_jump_op: begin
              cyc = `MBS_CYC_ABS_JMP;
              pc_out_nxt = abs_target;
            end
            mbs_pkg::relative_call_op: begin
              cyc = `MBS_CYC_REL_CALL;
              pc_out_nxt = rel_target(pc_in, rel_off);
            end
            mbs_pkg::absolute_call_op: begin
              cyc = `MBS_CYC_ABS_CALL;
              pc_out_nxt = abs_target;
            end
            mbs_pkg::compare_op, mbs_pkg::compare_carry_op, mbs_pkg::compare_immediate_op: begin
              cyc = `MBS_CYC_CMP;
              pend_flags_nxt = 1'b1;
              flags_out_nxt[`MBS_FLG_N] = diff[7];
              flags_out_nxt[`MBS_FLG_H] = (!opd_a[3] & source_operand[3]) |
                (source_operand[3] & diff[3]) | (diff[3] & !opd_a[3]);
              flags_out_nxt[`MBS_FLG_V] = (opd_a[7] & !source_operand[7] & !diff[7]) |
                (!opd_a[7] & source_operand[7] & diff[7]);
              flags_out_nxt[`MBS_FLG_C] = (!opd_a[7] & source_operand[7]) |
                (source_operand[7] & diff[7]) | (diff[7] & !opd_a[7]);
              // With carry, zero only survives a chain of zero bytes
              flags_out_nxt[`MBS_FLG_Z] = (diff == 8'h00) &&
                ((op != mbs_pkg::compare_carry_op) || status_flags_register[`MBS_FLG_Z]);
            end
            mbs_pkg::compare_skip_equal_op, mbs_pkg::skip_reg_bit_clear_op,
            mbs_pkg::skip_reg_bit_set_op, mbs_pkg::skip_io_bit_clear_op,
            mbs_pkg::skip_io_bit_set_op: begin
              cyc = skip_cyc;
              pc_out_nxt = skip_pc;
            end
            default: begin
              // Every remaining code is a flag-driven branch
              cyc = br_taken ? `MBS_CYC_BR_TAKEN : `MBS_CYC_BR_NOT;
              if (br_taken) begin
                pc_out_nxt = rel_target(pc_in, rel_off);
              end
            end
          endcase
          cnt_nxt = cyc - 3'h1;
          state_nxt = mbs_pkg::st_run;
        end
      end
      mbs_pkg::st_run: begin
        if (cnt_r == 3'h0) begin
          done_nxt = 1'b1;
          pc_load_nxt = 1'b1;
          prod_we_nxt = pend_prod_r;
          flags_we_nxt = pend_flags_r;
          state_nxt = mbs_pkg::st_idle;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      default: state_nxt = mbs_pkg::st_idle;
    endcase
    busy_nxt = (state_nxt == mbs_pkg::st_run);
  end

  // Register stage; all outputs come straight from here
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= mbs_pkg::st_idle;
      cnt_r <= `MBS_RST_CNT;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      pc_load_r <= 1'b0;
      pc_out_r <= `MBS_RST_PC;
      prod_we_r <= 1'b0;
      product_register_pair <= `MBS_RST_PROD;
      flags_we_r <= 1'b0;
      flags_out_r <= `MBS_RST_FLAGS;
      pend_prod_r <= 1'b0;
      pend_flags_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      pc_load_r <= pc_load_nxt;
      pc_out_r <= pc_out_nxt;
      prod_we_r <= prod_we_nxt;
      product_register_pair <= prod_nxt;
      flags_we_r <= flags_we_nxt;
      flags_out_r <= flags_out_nxt;
      pend_prod_r <= pend_prod_nxt;
      pend_flags_r <= pend_flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_take(mbs_pkg::mbs_op_type o);
    take && (op == o);
  endsequence
  sequence s_two_cycles;
    ##1 !done_r [*2] ##1 done_r;
  endsequence

  a_mul_two_cycles: assert property (s_take(mbs_pkg::multiply_unsigned_op) |-> s_two_cycles
    ##0 prod_we_r && product_register_pair == ($past(opd_a, 3) * $past(source_operand, 3)))
    else $error("unsigned multiply result or timing wrong");
  a_fractional_multiply_unsigned_op_shifted: assert property (s_take(mbs_pkg::fractional_multiply_unsigned_op) |->
    s_two_cycles ##0 product_register_pair == (($past(opd_a, 3) * $past(source_operand, 3)) << 1))
    else $error("fractional multiply not shifted");
  a_ptr_jump_z: assert property (s_take(mbs_pkg::pointer_jump_op) |-> s_two_cycles
    ##0 pc_load_r && !flags_we_r && pc_out_r == $past(z_ptr, 3))
    else $error("pointer jump target or timing wrong");
  a_relative_call_op_target: assert property (s_take(mbs_pkg::relative_call_op) |->
    ##1 !done_r [*3] ##1 done_r && pc_out_r == rel_target($past(pc_in, 4), $past(rel_off, 4)))
    else $error("relative call target or timing wrong");
  a_call_four: assert property (s_take(mbs_pkg::absolute_call_op) |->
    ##1 !done_r [*4] ##1 done_r && !flags_we_r)
    else $error("absolute call not four cycles");
  a_skip_two_word: assert property (s_take(mbs_pkg::compare_skip_equal_op) &&
    opd_a == source_operand && next_two_word |->
    ##1 !done_r [*3] ##1 done_r && pc_out_r == $past(pc_in, 4) + `MBS_PC_SKIP_TWO)
    else $error("skip over two-word instruction wrong");
  a_cmp_one_cycle: assert property (s_take(mbs_pkg::compare_op) |-> ##1 !done_r ##1 done_r
    && flags_we_r && flags_out_r[`MBS_FLG_Z] == ($past(opd_a, 2) == $past(source_operand, 2)))
    else $error("compare flags or timing wrong");
  a_branch_not: assert property (take && op >= mbs_pkg::branch_flag_set_op && !br_taken |->
    ##1 !done_r ##1 done_r && pc_out_r == $past(pc_in, 2) + `MBS_PC_STEP)
    else $error("untaken branch not one cycle");
  a_lower_carry: assert property (s_take(mbs_pkg::branch_lower_op) &&
    status_flags_register[`MBS_FLG_C] |->
    s_two_cycles ##0 pc_out_r == rel_target($past(pc_in, 3), $past(rel_off, 3)))
    else $error("lower branch on carry wrong");

endmodule : mbs_exec

/* File: dv/mbs_fetch_model.sv */
// Far-side model: program counter, flag byte and register pair one:zero of the core
`timescale 1ns/1ps

module mbs_fetch_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic preset_en,
  input wire logic [15:0] preset_pc,
  input wire logic [7:0] preset_flags,
  input wire logic pc_load_r,
  input wire logic [15:0] pc_out_r,
  input wire logic flags_we_r,
  input wire logic [7:0] flags_out_r,
  input wire logic prod_we_r,
  input wire logic [15:0] product_register_pair,
  output logic [15:0] pc_in,
  output logic [7:0] status_flags_register,
  output logic [15:0] reg_pair
);
  // ----------------------------------------------------------------
  // Core state updated from the execution unit's strobes
  // ----------------------------------------------------------------
  logic [15:0] pc_r;
  logic [7:0] flags_r;

  // Strobes are taken at the edge that also takes the next request, as a real fetch does
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pc_r <= 16'h0000;
      flags_r <= 8'h00;
      reg_pair <= 16'h0000;
    end else begin
      if (pc_load_r) pc_r <= pc_out_r;
      if (flags_we_r) flags_r <= flags_out_r;
      if (prod_we_r) reg_pair <= product_register_pair;
    end
  end

  // The bench overrides the state in the request cycle, so one process drives each value
  assign pc_in = preset_en ? preset_pc : pc_r;
  assign status_flags_register = preset_en ? preset_flags : flags_r;
endmodule : mbs_fetch_model

/* File: dv/mbs_exec_tb.sv */
// Self-checking bench for the multiply, branch and skip execution unit
`timescale 1ns/1ps

module mbs_exec_tb;
  // ----------------------------------------------------------------
  // Stimulus, wiring and instances
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  mbs_pkg::mbs_op_type op = mbs_pkg::compare_op;
  logic [7:0] opd_a = 8'h00;
  logic [7:0] src_b = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] io_val = 8'h00;
  logic [11:0] rel_off = 12'h000;
  logic [15:0] abs_target = 16'h0000;
  logic [15:0] z_ptr = 16'h0000;
  logic next_two_word = 1'b0;
  logic preset_en = 1'b0;
  logic [15:0] preset_pc = 16'h0000;
  logic [7:0] preset_flags = 8'h00;
  logic [15:0] pc_in, pc_out_r, prod, pair;
  logic [7:0] flags_in, flags_out_r;
  logic busy_r, done_r, pc_load_r, prod_we_r, flags_we_r;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;

  // Free-running core clock
  always #12.5 clk_sys = ~clk_sys;

  mbs_exec dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .start(start), .op(op), .opd_a(opd_a),
    .source_operand(src_b), .bit_sel(bit_sel), .io_val(io_val), .rel_off(rel_off),
    .abs_target(abs_target), .z_ptr(z_ptr), .pc_in(pc_in), .status_flags_register(flags_in),
    .next_two_word(next_two_word), .busy_r(busy_r), .done_r(done_r), .pc_load_r(pc_load_r),
    .pc_out_r(pc_out_r), .prod_we_r(prod_we_r), .product_register_pair(prod),
    .flags_we_r(flags_we_r), .flags_out_r(flags_out_r));

  mbs_fetch_model fe (.clk_sys(clk_sys), .sys_rst(sys_rst), .preset_en(preset_en),
    .preset_pc(preset_pc), .preset_flags(preset_flags), .pc_load_r(pc_load_r),
    .pc_out_r(pc_out_r), .flags_we_r(flags_we_r), .flags_out_r(flags_out_r),
    .prod_we_r(prod_we_r), .product_register_pair(prod), .pc_in(pc_in),
    .status_flags_register(flags_in), .reg_pair(pair));

  // ----------------------------------------------------------------
  // Shared tasks and reference functions
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Issues one request and counts edges to done; a request may follow in the done cycle
  task automatic exec(input mbs_pkg::mbs_op_type o, input logic [15:0] pc, input logic [7:0] f);
    preset_pc = pc;
    preset_flags = f;
    preset_en = 1'b1;
    op = o;
    start = 1'b1;
    @(posedge clk_sys);
    #1;
    start = 1'b0;
    preset_en = 1'b0;
    chk("busy_r", 16'h0001, {15'h0000, busy_r});
    cyc = 0;
    while (done_r !== 1'b1) begin
      if (cyc == 8) begin
        errors++;
        $display("mismatch done_r expected 1 seen %b", done_r);
        conclude();
      end
      @(posedge clk_sys);
      #1;
      cyc++;
    end
  endtask : exec

  // Judges the completion cycle: latency, next address and write strobes
  task automatic post(input int n, input logic [15:0] pc, input logic fwe, input logic pwe);
    chk("cycles", 16'(n), 16'(cyc));
    chk("pc_out_r", pc, pc_out_r);
    chk("strobes", {12'h000, 1'b0, 1'b1, fwe, pwe},
      {12'h000, busy_r, pc_load_r, flags_we_r, prod_we_r});
  endtask : post

  // Compare flags; the carry variant keeps zero only if it was already set
  function automatic logic [7:0] cmp_flags(input logic [7:0] a, b, f, input logic wc);
    logic cin;
    logic [8:0] d;
    logic [4:0] h;
    cin = wc & f[0];
    d = {1'b0, a} - {1'b0, b} - 9'(cin);
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(cin);
    cmp_flags = f;
    cmp_flags[0] = d[8];
    cmp_flags[1] = (d[7:0] == 8'h00) & (~wc | f[1]);
    cmp_flags[2] = d[7];
    cmp_flags[3] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
    cmp_flags[5] = h[4];
  endfunction : cmp_flags

  function automatic logic br_taken(input mbs_pkg::mbs_op_type o, input logic [7:0] f,
                                    input logic [2:0] s);
    case (o)
      mbs_pkg::branch_flag_set_op: br_taken = f[s];
      mbs_pkg::branch_flag_clear_op: br_taken = ~f[s];
      mbs_pkg::branch_same_higher_op: br_taken = ~f[0];
      mbs_pkg::branch_lower_op: br_taken = f[0];
      mbs_pkg::branch_signed_less_op: br_taken = f[2] ^ f[3];
      mbs_pkg::branch_irq_enabled_op: br_taken = f[7];
      mbs_pkg::branch_irq_disabled_op: br_taken = ~f[7];
      mbs_pkg::branch_half_carry_set_op: br_taken = f[5];
      mbs_pkg::branch_half_carry_clear_op: br_taken = ~f[5];
      mbs_pkg::branch_transfer_bit_set_op: br_taken = f[6];
      mbs_pkg::branch_transfer_bit_clear_op: br_taken = ~f[6];
      mbs_pkg::branch_overflow_set_op: br_taken = f[3];
      default: br_taken = ~f[3];
    endcase
  endfunction : br_taken

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("idle strobes", 16'h0000, {busy_r, done_r, pc_load_r, prod_we_r, flags_we_r, 11'h000});
    chk("idle pc_out_r", 16'h0000, pc_out_r);
    chk("idle product", 16'h0000, prod);
  endtask : t_reset

  // Six multiply kinds on signed corner operands, one idle cycle apart for the register pair check
  task automatic t_mul();
    logic [15:0] sa, ua, sb, ub, p, r;
    logic [7:0] av [3] = '{8'h80, 8'h00, 8'hC3};
    logic [7:0] bv [3] = '{8'hFF, 8'h35, 8'h7E};
    for (int i = 0; i < 18; i++) begin
      opd_a = av[i % 3];
      src_b = bv[i % 3];
      sa = {{8{opd_a[7]}}, opd_a};
      ua = {8'h00, opd_a};
      sb = {{8{src_b[7]}}, src_b};
      ub = {8'h00, src_b};
      p = ((i / 3) % 3 == 0) ? ua * ub : ((i / 3) % 3 == 1) ? sa * sb : sa * ub;
      r = (i >= 9) ? {p[14:0], 1'b0} : p;
      exec(mbs_pkg::mbs_op_type'(6'(i / 3)), 16'h0200, 8'h5A);
      post(2, 16'h0201, 1'b1, 1'b1);
      chk("product", r, prod);
      chk("flags_out_r", {8'h00, 6'h16, r == 16'h0000, p[15]}, {8'h00, flags_out_r});
      @(posedge clk_sys);
      #1;
      chk("reg_pair", r, pair);
    end
  endtask : t_mul

  // Jumps and calls with flags all set, which must not be written
  task automatic t_jumps();
    rel_off = 12'hFF0;
    z_ptr = 16'h1234;
    abs_target = 16'h3C00;
    exec(mbs_pkg::relative_jump_op, 16'h0100, 8'hFF);
    post(2, 16'h00F1, 1'b0, 1'b0);
    exec(mbs_pkg::pointer_jump_op, 16'h0100, 8'hFF);
    post(2, 16'h1234, 1'b0, 1'b0);
    exec(mbs_pkg::absolute_jump_op, 16'h0100, 8'hFF);
    post(3, 16'h3C00, 1'b0, 1'b0);
    exec(mbs_pkg::relative_call_op, 16'h0100, 8'hFF);
    post(3, 16'h00F1, 1'b0, 1'b0);
    rel_off = 12'h7FF;
    exec(mbs_pkg::relative_call_op, 16'hFF00, 8'hFF);
    post(3, 16'h0700, 1'b0, 1'b0);
    exec(mbs_pkg::absolute_call_op, 16'h0100, 8'hFF);
    post(4, 16'h3C00, 1'b0, 1'b0);
  endtask : t_jumps

  task automatic t_compare();
    logic [7:0] v [6] = '{8'h00, 8'h01, 8'h10, 8'h7F, 8'h80, 8'hFF};
    logic [7:0] f;
    for (int k = 0; k < 3; k++) for (int i = 0; i < 36; i++) for (int g = 0; g < 2; g++) begin
      opd_a = v[i / 6];
      src_b = v[i % 6];
      f = g[0] ? 8'hFF : 8'h00;
      exec(mbs_pkg::mbs_op_type'(6'(12 + k)), 16'h0300, f);
      post(1, 16'h0301, 1'b1, 1'b0);
      chk("flags_out_r", {8'h00, cmp_flags(opd_a, src_b, f, k == 1)}, {8'h00, flags_out_r});
    end
  endtask : t_compare

  // Every skip kind on every bit, over one- and two-word followers
  task automatic t_skip();
    logic sk;
    int n;
    io_val = 8'hA5;
    src_b = 8'h5A;
    for (int t = 0; t < 2; t++) for (int b = 0; b < 8; b++) for (int k = 0; k < 5; k++) begin
      next_two_word = t[0];
      bit_sel = b[2:0];
      opd_a = b[0] ? 8'h5A : 8'h5B;
      case (k)
        0: sk = (opd_a == src_b);
        1: sk = ~src_b[b];
        2: sk = src_b[b];
        3: sk = ~io_val[b];
        default: sk = io_val[b];
      endcase
      n = sk ? (t == 1 ? 3 : 2) : 1;
      exec(mbs_pkg::mbs_op_type'(6'(k == 0 ? 11 : 14 + k)), 16'h0400, 8'h3C);
      post(n, 16'h0400 + 16'(n), 1'b0, 1'b0);
    end
  endtask : t_skip

  // Every branch kind against all flag bytes, forward and backward offsets
  task automatic t_branch();
    logic tk;
    logic [15:0] tgt;
    for (int k = 19; k < 32; k++) for (int f = 0; f < 256; f++) begin
      bit_sel = 3'(f + 3);
      rel_off = f[4] ? 12'hFC0 : 12'h03F;
      tk = br_taken(mbs_pkg::mbs_op_type'(6'(k)), 8'(f), bit_sel);
      tgt = tk ? 16'h0800 + {{4{rel_off[11]}}, rel_off} + 16'h0001 : 16'h0801;
      exec(mbs_pkg::mbs_op_type'(6'(k)), 16'h0800, 8'(f));
      post(tk ? 2 : 1, tgt, 1'b0, 1'b0);
    end
  endtask : t_branch

  // Main sequence: reset held for six cycles, then every scenario
  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_mul();
    t_jumps();
    t_compare();
    t_skip();
    t_branch();
    conclude();
  end
endmodule : mbs_exec_tb
